// ==== core/cd_pkg.sv ====
// Purpose: shared constants for the channel diagnostics block
// Assumes: one channel, single clock at 25 MHz
// Notes: register offsets and loop codes are local choices
package cd_pkg;
   localparam int cd_addr_w = 4;
   localparam logic [3:0] cd_ctrl_off = 4'h0;
   localparam logic [3:0] cd_inject_off = 4'h1;
   localparam logic [3:0] cd_status_off = 4'h2;
   // control register bit positions
   localparam int cd_prbs_en_pos = 0;
   localparam int cd_rate_e3_pos = 1;
   localparam int cd_local_loop_pos = 2;
   localparam int cd_remote_loop_pos = 3;
   localparam int cd_all_ones_pos = 4;
   localparam int cd_dual_pos = 5;
   localparam logic [5:0] cd_ctrl_rst = 6'h00;
   // loop select codes {remote, local}
   localparam logic [1:0] cd_loop_normal = 2'h0;
   localparam logic [1:0] cd_loop_digital = 2'h1;
   localparam logic [1:0] cd_loop_remote = 2'h2;
   localparam logic [1:0] cd_loop_analog = 2'h3;
   // lfsr lengths and taps
   localparam int cd_len_e3 = 23;
   localparam int cd_tap_e3 = 18;
   localparam int cd_len_ds3 = 15;
   localparam int cd_tap_ds3 = 14;
   // checker lock: good bits to sync, bad bits to drop
   localparam logic [5:0] cd_lock_count = 6'h20;
   localparam logic [3:0] cd_loss_count = 4'h8;
   typedef enum logic [2:0] {
      cd_hunt = 3'b001,
      cd_verify = 3'b010,
      cd_locked = 3'b100
   } cd_chk_state_type;
endpackage

// ==== core/cd_prbs_gen.sv ====
// Purpose: prbs generator with single error insertion
// Assumes: advances one bit per clk cycle when enabled
// Notes: sequence length chosen by rate select
`timescale 1ns/1ns
module cd_prbs_gen (
   input wire logic clk, // clock
   input wire logic rst_n, // synchronised reset
   input wire logic enable, // generator running
   input wire logic rate_e3, // 1: 2^23-1, 0: 2^15-1
   input wire logic inject, // one-cycle error request
   output logic bit_out // generated bit
);
   import cd_pkg::*;
   logic [22:0] lfsr_r;
   logic fb;
   always_comb begin
      if (rate_e3) begin
         fb = lfsr_r[cd_len_e3-1] ^ lfsr_r[cd_tap_e3-1];
      end else begin
         fb = lfsr_r[cd_len_ds3-1] ^ lfsr_r[cd_tap_ds3-1];
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lfsr_r <= 23'h7fffff;
      end else if (enable) begin
         lfsr_r <= {lfsr_r[21:0], fb};
      end
   end
   // [RULE5] flip one output bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_out <= 1'b0;
      end else begin
         bit_out <= enable & (fb ^ inject);
      end
   end
endmodule

// ==== core/cd_prbs_chk.sv ====
// Purpose: prbs checker with sync tracking and error pulses
// Assumes: self-synchronising by seeding from received bits
// Notes: loss after cd_loss_count consecutive errors
`timescale 1ns/1ns
module cd_prbs_chk (
   input wire logic clk, // clock
   input wire logic rst_n, // synchronised reset
   input wire logic enable, // checker running
   input wire logic rate_e3, // sequence length select
   input wire logic bit_in, // received bit
   output logic in_sync, // locked to pattern
   output logic err_pulse // one cycle per bad bit while locked
);
   import cd_pkg::*;
   cd_chk_state_type state_r;
   logic [22:0] shr_r;
   logic [5:0] good_r;
   logic [3:0] bad_r;
   logic pred, miss;
   assign pred = rate_e3 ? shr_r[cd_len_e3-1] ^ shr_r[cd_tap_e3-1]
                         : shr_r[cd_len_ds3-1] ^ shr_r[cd_tap_ds3-1];
   assign miss = pred ^ bit_in;
   assign in_sync = (state_r == cd_locked);
   // seeding from the line keeps realignment free of a search
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shr_r <= 23'h000000;
      end else if (enable) begin
         // flywheel once locked: one line error costs one miss only
         shr_r <= {shr_r[21:0], in_sync ? pred : bit_in};
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= cd_hunt;
         good_r <= 6'h00;
         bad_r <= 4'h0;
      end else if (!enable) begin
         state_r <= cd_hunt;
         good_r <= 6'h00;
         bad_r <= 4'h0;
      end else begin
         unique case (state_r)
            cd_hunt: begin
               good_r <= 6'h00;
               if (!miss) begin
                  state_r <= cd_verify;
               end
            end
            cd_verify: begin
               if (miss) begin
                  state_r <= cd_hunt;
               end else if (good_r == cd_lock_count - 6'h01) begin
                  state_r <= cd_locked;
                  bad_r <= 4'h0;
               end else begin
                  good_r <= good_r + 6'h01;
               end
            end
            cd_locked: begin
               if (!miss) begin
                  bad_r <= 4'h0;
               end else if (bad_r == cd_loss_count - 4'h1) begin
                  state_r <= cd_hunt;
               end else begin
                  bad_r <= bad_r + 4'h1;
               end
            end
         endcase
      end
   end
   // [RULE6] one pulse per error
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         err_pulse <= 1'b0;
      end else begin
         err_pulse <= enable & in_sync & miss;
      end
   end
endmodule

// ==== core/cd_channel_diag.sv ====
// Purpose: per-channel diagnostics: prbs, loopbacks, all-ones
// Assumes: line and data pins sampled on clk; clk stands for
//          the channel's transmit and recovered clocks
// Notes: analog path modelled as a digital short of line pins
`timescale 1ns/1ns
// Function
// [RULE1] prbs enable sends rate-dependent sequence
// [RULE2] prbs enable also enables checker
// [RULE3] negative output low when synchronised
// [RULE4] lock-lost flag and output high unsynchronised; in digital loop the output carries the looped negative rail instead
// [RULE5] inject bit inserts one bit error
// [RULE6] one-cycle high pulse per error
// [RULE7] injection only on zero-to-one write
// [RULE8] prbs mode forces single-rail operation
// [RULE9] two select bits choose loopback mode
// [RULE10] analog loop feeds transmit into receiver
// [RULE11] analog loop keeps transmitting, ignores line
// [RULE12] analog loop passes through jitter attenuator
// [RULE13] digital loop returns transmit clock, data
// [RULE14] remote loop retransmits received data
// [RULE15] remote loop still outputs received data
// [RULE16] remote loop ignores transmit inputs
// [RULE17] all-ones bit sends AMI ones
// [RULE18] all-ones timed by transmit clock
// [RULE19] all-ones inactive in analog, remote loops
// [RULE20] loop code mapping fixed in package
module cd_channel_diag (
   clk, // 25 MHz clock
   nrst, // async reset, active low
   addr, // register address
   wdata, // write data
   wr, // write strobe
   rd, // read strobe
   rdata, // read data, cycle after rd
   ja_present, // jitter attenuator in loop path
   tx_clock_in, // transmit clock from terminal
   tx_pos_data, // transmit positive rail / single data
   tx_neg_data, // transmit negative rail
   rx_line_pos, // line receive positive
   rx_line_neg, // line receive negative
   tx_line_pos, // line transmit positive
   tx_line_neg, // line transmit negative
   rx_clock_out, // receive clock to terminal
   rx_pos_data, // receive positive rail / data
   rx_neg_violation_out, // receive negative rail / prbs status
   sequence_lock_lost_flag // checker not synchronised
);
   import cd_pkg::*;
   input wire logic clk;
   input wire logic nrst;
   input wire logic [cd_pkg::cd_addr_w-1:0] addr;
   input wire logic [7:0] wdata;
   input wire logic wr;
   input wire logic rd;
   output logic [7:0] rdata;
   input wire logic ja_present;
   input wire logic tx_clock_in;
   input wire logic tx_pos_data;
   input wire logic tx_neg_data;
   input wire logic rx_line_pos;
   input wire logic rx_line_neg;
   output logic tx_line_pos;
   output logic tx_line_neg;
   output logic rx_clock_out;
   output logic rx_pos_data;
   output logic rx_neg_violation_out;
   output logic sequence_lock_lost_flag;

   logic rst_a_r, rst_n;
   logic [5:0] ctrl_r;
   logic error_inject_bit_r;
   logic inject_pulse;
   logic prbs_enable_bit, rate_e3, tx_all_ones_ctl, dual_rail;
   logic [1:0] loop_mode;
   logic gen_bit, in_sync, err_pulse;
   logic tx_clk_d_r, tx_tick;
   logic ones_phase_r;
   logic ja_pos_r, ja_neg_r;
   logic src_pos, src_neg, line_pos, line_neg;
   logic rx_pos_in, rx_neg_in;
   logic [7:0] rd_val;

   // reset release through two flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_a_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_a_r <= 1'b1;
         rst_n <= rst_a_r;
      end
   end

   // [RULE20] loop code is {remote, local}
   function automatic logic [1:0] loop_decode(input logic [5:0] c);
      loop_decode = {c[cd_remote_loop_pos], c[cd_local_loop_pos]};
   endfunction

   assign prbs_enable_bit = ctrl_r[cd_prbs_en_pos];
   assign rate_e3 = ctrl_r[cd_rate_e3_pos];
   assign tx_all_ones_ctl = ctrl_r[cd_all_ones_pos];
   // [RULE9] remote and local select
   assign loop_mode = loop_decode(ctrl_r);
   // [RULE8] prbs forces single rail
   assign dual_rail = ctrl_r[cd_dual_pos] & ~prbs_enable_bit;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= cd_ctrl_rst;
      end else if (wr && addr == cd_ctrl_off) begin
         ctrl_r <= wdata[5:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         error_inject_bit_r <= 1'b0;
      end else if (wr && addr == cd_inject_off) begin
         error_inject_bit_r <= wdata[0];
      end
   end
   // [RULE7] edge-triggered injection
   // a repeated 1 write does nothing; software clears first
   assign inject_pulse = wr && addr == cd_inject_off && wdata[0]
                         && !error_inject_bit_r && prbs_enable_bit;

   // [RULE18] transmit timing from tx clock edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_clk_d_r <= 1'b0;
      end else begin
         tx_clk_d_r <= tx_clock_in;
      end
   end
   assign tx_tick = tx_clock_in & ~tx_clk_d_r;

   // [RULE1] generator runs while enabled
   cd_prbs_gen u_gen (
      .clk(clk),
      .rst_n(rst_n),
      .enable(prbs_enable_bit),
      .rate_e3(rate_e3),
      .inject(inject_pulse),
      .bit_out(gen_bit)
   );

   // [RULE17] AMI ones alternate polarity each tick
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ones_phase_r <= 1'b0;
      end else if (tx_tick) begin
         ones_phase_r <= ~ones_phase_r;
      end
   end

   // transmit source selection
   always_comb begin
      if (loop_mode == cd_loop_remote) begin
         // [RULE14] received data retransmitted
         // [RULE16] tx inputs ignored
         src_pos = rx_line_pos;
         src_neg = rx_line_neg;
      end else if (tx_all_ones_ctl && loop_mode != cd_loop_analog) begin
         // [RULE19] all-ones only outside analog and remote
         // one mark per rising clock edge: a stopped clock sends nothing
         src_pos = tx_tick & ~ones_phase_r;
         src_neg = tx_tick & ones_phase_r;
      end else if (prbs_enable_bit) begin
         src_pos = gen_bit;
         src_neg = 1'b0;
      end else begin
         src_pos = tx_pos_data;
         src_neg = dual_rail ? tx_neg_data : 1'b0;
      end
   end

   // [RULE12] attenuator stage, bypassed when absent
   // modelled as a single retiming flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ja_pos_r <= 1'b0;
         ja_neg_r <= 1'b0;
      end else begin
         ja_pos_r <= src_pos;
         ja_neg_r <= src_neg;
      end
   end
   assign line_pos = ja_present ? ja_pos_r : src_pos;
   assign line_neg = ja_present ? ja_neg_r : src_neg;

   // [RULE11] line outputs keep driving in analog loop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_line_pos <= 1'b0;
         tx_line_neg <= 1'b0;
      end else begin
         tx_line_pos <= line_pos;
         tx_line_neg <= line_neg;
      end
   end

   // [RULE10] analog loop feeds tx line into receiver
   assign rx_pos_in = (loop_mode == cd_loop_analog) ? tx_line_pos
                                                     : rx_line_pos;
   assign rx_neg_in = (loop_mode == cd_loop_analog) ? tx_line_neg
                                                     : rx_line_neg;

   // [RULE2] checker enabled with generator
   cd_prbs_chk u_chk (
      .clk(clk),
      .rst_n(rst_n),
      .enable(prbs_enable_bit),
      .rate_e3(rate_e3),
      .bit_in(rx_pos_in),
      .in_sync(in_sync),
      .err_pulse(err_pulse)
   );

   // [RULE4] lock lost flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sequence_lock_lost_flag <= 1'b0;
      end else begin
         sequence_lock_lost_flag <= prbs_enable_bit & ~in_sync;
      end
   end

   // receive side outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_clock_out <= 1'b0;
         rx_pos_data <= 1'b0;
         rx_neg_violation_out <= 1'b0;
      end else if (loop_mode == cd_loop_digital) begin
         // [RULE13] digital loop returns tx clock and data
         rx_clock_out <= tx_clock_in;
         rx_pos_data <= src_pos;
         rx_neg_violation_out <= src_neg;
      end else begin
         rx_clock_out <= tx_clock_in;
         // [RULE15] received data still presented
         rx_pos_data <= rx_pos_in;
         if (prbs_enable_bit) begin
            // [RULE3] low in sync, [RULE6] pulse on error
            rx_neg_violation_out <= ~in_sync | err_pulse;
         end else begin
            rx_neg_violation_out <= dual_rail & rx_neg_in;
         end
      end
   end

   // register read, one cycle latency
   always_comb begin
      rd_val = 8'h00;
      unique case (addr)
         cd_ctrl_off: rd_val = {2'h0, ctrl_r};
         cd_inject_off: rd_val = {7'h00, error_inject_bit_r};
         cd_status_off: rd_val = {6'h00, in_sync,
                                  sequence_lock_lost_flag};
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         rdata <= rd_val;
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule

// ==== dv/cd_diag_properties.sv ====
// Purpose: port-level properties of the channel diagnostics block
// Assumes: control bits mirrored from bus writes to the control register
// Notes: attached by bind below the module
`timescale 1ns/1ns
module cd_diag_props (
   input wire logic clk, // clock
   input wire logic nrst, // async reset, active low
   input wire logic [cd_pkg::cd_addr_w-1:0] addr, // register address
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [7:0] rdata, // read data
   input wire logic tx_clock_in, // transmit clock
   input wire logic tx_line_pos, // line out positive
   input wire logic tx_line_neg, // line out negative
   input wire logic rx_clock_out, // receive clock out
   input wire logic rx_neg_violation_out, // rail or status output
   input wire logic sequence_lock_lost_flag // checker not locked
);
   import cd_pkg::*;
   logic [5:0] ctrl_r;
   logic [1:0] loop_w;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r <= cd_ctrl_rst;
      end else if (wr && addr == cd_ctrl_off) begin
         ctrl_r <= wdata[5:0];
      end
   end
   assign loop_w = {ctrl_r[cd_remote_loop_pos], ctrl_r[cd_local_loop_pos]};
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence ctrl_wr_s;
      wr && addr == cd_ctrl_off;
   endsequence
   sequence ctrl_rd_s;
      rd && !wr && addr == cd_ctrl_off;
   endsequence
   lost_flag_high_a: assert property (
      sequence_lock_lost_flag |-> rx_neg_violation_out)
      else $error("lock lost but status output low");
   lost_needs_prbs_a: assert property (
      !ctrl_r[cd_prbs_en_pos] && !$past(ctrl_r[cd_prbs_en_pos])
      |-> !sequence_lock_lost_flag)
      else $error("lock lost flag set with prbs off");
   idle_rdata_zero_a: assert property (
      !rd |=> rdata == 8'h00)
      else $error("read data without read");
   unmapped_read_a: assert property (
      rd && addr > cd_status_off |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   ctrl_readback_a: assert property (
      ctrl_wr_s ##1 ctrl_rd_s |=> rdata[5:0] == $past(wdata[5:0], 2))
      else $error("control readback mismatch");
   digital_clock_a: assert property (
      loop_w == cd_loop_digital && $past(loop_w) == cd_loop_digital
      |-> rx_clock_out == $past(tx_clock_in))
      else $error("receive clock not looped");
   ami_one_rail_a: assert property (
      ctrl_r[cd_all_ones_pos] && loop_w == cd_loop_normal
      |-> !(tx_line_pos && tx_line_neg))
      else $error("both line rails high");
   prbs_single_a: assert property (
      ctrl_r[cd_prbs_en_pos] && $past(ctrl_r[cd_prbs_en_pos], 3)
      && !ctrl_r[cd_all_ones_pos] && loop_w == cd_loop_normal
      && $past(loop_w, 3) == cd_loop_normal |-> !tx_line_neg)
      else $error("negative rail used in prbs mode");
endmodule
bind cd_channel_diag cd_diag_props u_props (.clk(clk), .nrst(nrst),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .tx_clock_in(tx_clock_in), .tx_line_pos(tx_line_pos),
   .tx_line_neg(tx_line_neg), .rx_clock_out(rx_clock_out),
   .rx_neg_violation_out(rx_neg_violation_out),
   .sequence_lock_lost_flag(sequence_lock_lost_flag));

// ==== dv/cd_line_model.sv ====
// Purpose: far-end line: echo, steady level, noise or inverted echo
// Assumes: one bit per clk on each rail
// Notes: noise mode proves the receiver ignores the line
`timescale 1ns/1ns
module cd_line_model (
   input wire logic clk, // clock
   input wire logic [1:0] mode, // 0 echo, 1 steady, 2 noise, 3 inverted
   input wire logic level, // steady level
   input wire logic tx_pos, // from device, positive
   input wire logic tx_neg, // from device, negative
   output logic rx_pos, // to device, positive
   output logic rx_neg // to device, negative
);
   logic [2:0] lfsr_r;
   initial begin
      lfsr_r = 3'h1;
      rx_pos = 1'b0;
      rx_neg = 1'b0;
   end
   always @(posedge clk) begin
      lfsr_r <= {lfsr_r[1:0], lfsr_r[2] ^ lfsr_r[1]};
      case (mode)
         2'h0: begin
            rx_pos <= tx_pos;
            rx_neg <= tx_neg;
         end
         2'h1: begin
            rx_pos <= level;
            rx_neg <= 1'b0;
         end
         // every bit wrong: forces a steady run of misses
         2'h3: begin
            rx_pos <= ~tx_pos;
            rx_neg <= 1'b0;
         end
         default: begin
            rx_pos <= lfsr_r[0];
            rx_neg <= ~lfsr_r[0];
         end
      endcase
   end
endmodule

// ==== dv/tb_channel_diagnostics.sv ====
// Purpose: register-driven tests of loops, all-ones and prbs
// Assumes: line model on the far side
// Notes: settle delays cover the two or three flop latency
`timescale 1ns/1ns
module tb_channel_diagnostics;
   import cd_pkg::*;
   logic clk, nrst, wr, rd, ja, txc, txp, txn, txclk_run, llvl;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   logic [1:0] lmode;
   logic rlp, rln, tlp, tln, rxc, rxp, rxn, lost;
   int fail_count = 0;
   int checks_done = 0;
   cd_channel_diag dut (.clk(clk), .nrst(nrst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ja_present(ja),
      .tx_clock_in(txc), .tx_pos_data(txp), .tx_neg_data(txn),
      .rx_line_pos(rlp), .rx_line_neg(rln), .tx_line_pos(tlp),
      .tx_line_neg(tln), .rx_clock_out(rxc), .rx_pos_data(rxp),
      .rx_neg_violation_out(rxn), .sequence_lock_lost_flag(lost));
   cd_line_model line (.clk(clk), .mode(lmode), .level(llvl),
      .tx_pos(tlp), .tx_neg(tln), .rx_pos(rlp), .rx_neg(rln));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (txclk_run) begin
         txc <= ~txc;
      end
   end
   task automatic end_of_test();
      $display("checks %0d, errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp, "read data");
   endtask
   // write then read straight after, no gap
   task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, d, "readback");
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return rxp;
         1: return tlp;
         2: return lost;
         default: return rxn;
      endcase
   endfunction
   // bounded wait for a level, then it must stay for 8 cycles
   task automatic wait_hold(input int s, input logic v, input int lim);
      int i;
      i = 0;
      do begin
         @(posedge clk);
         #1;
         i++;
      end while (pick(s) !== v && i < lim);
      if (pick(s) !== v) begin
         chk(8'h00, 8'h01, "wait ran out");
         end_of_test();
      end
      repeat (8) begin
         @(posedge clk);
         #1;
         chk({7'h0, pick(s)}, {7'h0, v}, "held level");
      end
   endtask
   task automatic marks(input logic [7:0] c, input logic on);
      int np, nn;
      np = 0;
      nn = 0;
      wr_reg(cd_ctrl_off, c);
      repeat (4) @(posedge clk);
      repeat (40) begin
         @(posedge clk);
         #1;
         np += (tlp === 1'b1);
         nn += (tln === 1'b1);
      end
      chk({7'h0, np > 0 && nn > 0}, {7'h0, on}, "marks on both rails");
      chk({7'h0, on || np + nn == 0}, 8'h01, "line quiet");
   endtask
   // a single injected error must give one high cycle
   task automatic pulse_chk(input logic [7:0] d, input int want);
      int n;
      n = 0;
      wr_reg(cd_inject_off, d);
      repeat (24) begin
         @(posedge clk);
         #1;
         n += (rxn === 1'b1);
      end
      chk(8'(n), 8'(want), "error pulse cycles");
   endtask
   initial begin
      nrst = 1'b0;
      {wr, rd, ja, txc, txp, txn, llvl} = 7'h00;
      {addr, wdata} = 12'h000;
      txclk_run = 1'b1;
      lmode = 2'h2;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rd_reg(cd_ctrl_off, 8'h00); // reset value
      rd_reg(cd_status_off, 8'h00); // idle status
      rd_reg(4'hf, 8'h00); // unmapped address
      wr_rd(cd_ctrl_off, 8'h24); // digital loop, dual rail
      txp <= 1'b1;
      wait_hold(0, 1'b1, 10); // data looped back
      txp <= 1'b0;
      wait_hold(0, 1'b0, 10); // data looped back
      ja <= 1'b1;
      wr_reg(cd_ctrl_off, 8'h2c);
      txp <= 1'b1;
      wait_hold(0, 1'b1, 10); // line noise ignored
      wait_hold(1, 1'b1, 10); // still transmits
      txp <= 1'b0;
      wait_hold(0, 1'b0, 10); // attenuator in path
      lmode <= 2'h1;
      llvl <= 1'b1;
      txp <= 1'b0;
      wr_reg(cd_ctrl_off, 8'h28);
      wait_hold(1, 1'b1, 10); // line sent back
      wait_hold(0, 1'b1, 10); // received data still output
      chk({7'h0, rxp}, 8'h01, "remote receive data");
      llvl <= 1'b0;
      ja <= 1'b0;
      marks(8'h10, 1'b1); // all ones normal
      marks(8'h14, 1'b1); // all ones in digital loop
      marks(8'h18, 1'b0); // none in remote loop
      marks(8'h1c, 1'b0); // none in analog loop
      txclk_run <= 1'b0;
      marks(8'h10, 1'b0); // stopped transmit clock
      txclk_run <= 1'b1;
      lmode <= 2'h0;
      wr_reg(cd_ctrl_off, 8'h01);
      wait_hold(3, 1'b1, 2); // unlocked output high
      wait_hold(2, 1'b0, 300); // checker locks
      wait_hold(3, 1'b0, 10); // locked output low
      rd_reg(cd_status_off, 8'h02); // in sync status
      pulse_chk(8'h01, 1); // one error
      pulse_chk(8'h01, 0); // no rising write
      pulse_chk(8'h00, 0); // clear first
      pulse_chk(8'h01, 1); // pulse width
      pulse_chk(8'h00, 0); // clear again
      wr_reg(cd_ctrl_off, 8'h00); // checker restarts on new rate
      wr_reg(cd_ctrl_off, 8'h23);
      wait_hold(2, 1'b0, 300); // long sequence, dual ignored
      pulse_chk(8'h01, 1); // single rail kept
      lmode <= 2'h3;
      wait_hold(2, 1'b1, 100); // lock lost on inverted line
      rd_reg(cd_status_off, 8'h01); // lost status
      end_of_test();
   end
endmodule
